// *** gpio_assign_chk.sv ***
// Port-level assertions for the GPIO line assignment block
`timescale 1ns/1ps
`default_nettype none
`include "gpio_assign_regs.svh"
module gpio_assign_chk #(
    parameter int MAIN_LINES = 5,
    parameter int SUS_LINES  = 9,
    parameter int CHIP_LINES = 12
) (
    input wire logic                  sys_clk,
    input wire logic                  reset,
    input wire logic                  wb_cyc_i,
    input wire logic                  wb_stb_i,
    input wire logic                  wb_ack_o,
    input wire logic [31:0]           wb_dat_o,
    input wire logic                  s3Standby,
    input wire logic [MAIN_LINES-1:0] mainOe,
    input wire logic [SUS_LINES-1:0]  suspendOut,
    input wire logic [SUS_LINES-1:0]  suspendOe,
    input wire logic [CHIP_LINES-1:0] chipIn,
    input wire logic [CHIP_LINES-1:0] chipOe,
    input wire logic                  sdioSelected
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    // Eight samples cover the three-stage synchroniser plus the output register
    sequence s_req_taken; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
    sequence s_s3_settled; s3Standby [*8]; endsequence
    sequence s_sdio_settled; chipIn[8] [*8]; endsequence
    sequence s_gpio_settled; !chipIn[8] [*8]; endsequence
    a_ack_after_req: assert property (s_req_taken |=> wb_ack_o)
        else $error("no ack after request");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_data_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    a_main_oe_mask: assert property ((mainOe & ~`MAIN_DIR_MASK) == '0)
        else $error("main input-only line driven");
    a_sus_spare_input: assert property ((suspendOe & ~`SUS_DIR_MASK) == '0)
        else $error("spare suspend line driven");
    a_chip_spare_input: assert property ((chipOe & ~`CHIP_DIR_MASK) == '0)
        else $error("reserved chipset line driven");
    a_s3_main_off: assert property (s_s3_settled |-> mainOe == '0)
        else $error("main line driven in standby");
    // A reset or a bus write may legally move the suspend outputs, so both are excluded
    a_s3_sus_hold: assert property ((s3Standby && !wb_cyc_i && !$past(wb_cyc_i)
        && !$past(reset)) |-> $stable(suspendOut) && $stable(suspendOe))
        else $error("suspend output moved in standby");
    a_sdio_follow: assert property (s_sdio_settled |-> sdioSelected)
        else $error("sdio not selected");
    a_gpio_follow: assert property (s_gpio_settled |-> !sdioSelected)
        else $error("sdio selected while low");
endmodule // gpio_assign_chk
bind module_gpio_line_assignment gpio_assign_chk #(.MAIN_LINES(MAIN_LINES),
    .SUS_LINES(SUS_LINES), .CHIP_LINES(CHIP_LINES)) gpio_assign_chk_i (
    .sys_clk(sys_clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .s3Standby(s3Standby), .mainOe(mainOe),
    .suspendOut(suspendOut), .suspendOe(suspendOe), .chipIn(chipIn), .chipOe(chipOe),
    .sdioSelected(sdioSelected));
`default_nettype wire

// *** gpio_assign_pkg.sv ***
// Types shared by the GPIO line assignment block
package gpio_assign_pkg;
    typedef enum logic [0:0] {BUS_IDLE, BUS_ACK} bus_state_t;
endpackage

// *** gpio_assign_regs.svh ***
// Register offsets, field positions and reset values of the GPIO line assignment block
`ifndef GPIO_ASSIGN_REGS_SVH
`define GPIO_ASSIGN_REGS_SVH
`define MAIN_DIR_ADDR    8'h00
`define MAIN_OUT_ADDR    8'h04
`define MAIN_IN_ADDR     8'h08
`define SUS_DIR_ADDR     8'h0c
`define SUS_OUT_ADDR     8'h10
`define SUS_IN_ADDR      8'h14
`define CHIP_DIR_ADDR    8'h18
`define CHIP_OUT_ADDR    8'h1c
`define CHIP_IN_ADDR     8'h20
`define STANDBY_ADDR     8'h24
`define IRQ_STAT_ADDR    8'h28
`define IRQ_CLR_ADDR     8'h2c
`define IRQ_EN_ADDR      8'h30
`define MAIN_DIR_RST     5'h00
`define MAIN_DIR_MASK    5'h10
`define SUS_DIR_RST      9'h000
`define SUS_DIR_MASK     9'h09f
`define SUS_OUT_RST      9'h000
`define CHIP_DIR_RST     12'h000
`define CHIP_DIR_MASK    12'h1ff
`define MAIN_WDOG_BIT    4
`define MAIN_SER_BIT     3
`define MAIN_USB_BIT     1
`define CHIP_BATLOW_BIT  9
`define CHIP_SEL_BIT     8
`define IRQ_WDOG_BIT     0
`define IRQ_USB_BIT      1
`define IRQ_BATLOW_BIT   2
`define IRQ_CONN_BIT     3
`define IRQ_WIDTH        4
`define IRQ_RST          4'h0
`endif

// *** gpio_carrier_model.sv ***
// Carrier board model: resolves each pin from the module drive and carrier levels
`timescale 1ns/1ps
`default_nettype none
module gpio_carrier_model (
    input wire logic [4:0]  mainOut,
    input wire logic [4:0]  mainOe,
    input wire logic [8:0]  suspendOut,
    input wire logic [8:0]  suspendOe,
    input wire logic [11:0] chipOut,
    input wire logic [11:0] chipOe,
    input wire logic [4:0]  extMain,
    input wire logic [8:0]  extSus,
    input wire logic [11:0] extChip,
    output logic     [4:0]  mainIn,
    output logic     [8:0]  suspendIn,
    output logic     [11:0] chipIn
);
    // Carrier levels only show where the module has released the line
    assign mainIn = (mainOe & mainOut) | (~mainOe & extMain);
    assign suspendIn = (suspendOe & suspendOut) | (~suspendOe & extSus);
    assign chipIn = (chipOe & chipOut) | (~chipOe & extChip);
endmodule // gpio_carrier_model
`default_nettype wire

// *** module_gpio_line_assignment.sv ***
// GPIO line assignment: main, suspend and chipset ports behind a Wishbone slave
`timescale 1ns/1ps
`default_nettype none
`include "gpio_assign_regs.svh"
module module_gpio_line_assignment #(
    parameter int MAIN_LINES = 5,
    parameter int SUS_LINES  = 9,
    parameter int CHIP_LINES = 12
) (
    input  wire logic                  sys_clk,
    input  wire logic                  reset,
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [7:0]            wb_adr_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [31:0]           wb_dat_i,
    output logic      [31:0]           wb_dat_o,
    output logic                       wb_ack_o,
    input  wire logic                  s3Standby,
    input  wire logic [MAIN_LINES-1:0] mainIn,
    output logic      [MAIN_LINES-1:0] mainOut,
    output logic      [MAIN_LINES-1:0] mainOe,
    input  wire logic [SUS_LINES-1:0]  suspendIn,
    output logic      [SUS_LINES-1:0]  suspendOut,
    output logic      [SUS_LINES-1:0]  suspendOe,
    input  wire logic [CHIP_LINES-1:0] chipIn,
    output logic      [CHIP_LINES-1:0] chipOut,
    output logic      [CHIP_LINES-1:0] chipOe,
    output logic                       sdioSelected,
    output logic                       irq
);
    localparam int ALL = MAIN_LINES + SUS_LINES + CHIP_LINES + 1;

    // Three-stage synchronisers on every pin input and the standby level
    logic [ALL-1:0] syncA_ff, syncB_ff, syncC_ff, stable_ff;
    logic [ALL-1:0] nxt_stable;
    logic [MAIN_LINES-1:0] mainSync;
    logic [SUS_LINES-1:0]  susSync;
    logic [CHIP_LINES-1:0] chipSync;
    logic                  s3Sync;

    // Clearing the chain in reset means a high pin shows up as a late rise,
    // so software should treat events seen just after reset with care
    always_comb begin
        // A change counts only once the second and third stages agree
        nxt_stable = (syncB_ff & ~(syncB_ff ^ syncC_ff)) | (stable_ff & (syncB_ff ^ syncC_ff));
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            syncA_ff  <= '0;
            syncB_ff  <= '0;
            syncC_ff  <= '0;
            stable_ff <= '0;
        end else begin
            syncA_ff  <= {s3Standby, chipIn, suspendIn, mainIn};
            syncB_ff  <= syncA_ff;
            syncC_ff  <= syncB_ff;
            stable_ff <= nxt_stable;
        end
    end

    assign mainSync = stable_ff[MAIN_LINES-1:0];
    assign susSync  = stable_ff[MAIN_LINES +: SUS_LINES];
    assign chipSync = stable_ff[MAIN_LINES+SUS_LINES +: CHIP_LINES];
    assign s3Sync   = stable_ff[ALL-1];

    // Software state
    logic [MAIN_LINES-1:0] mainDir_ff, mainOutReg_ff, nxt_mainDir, nxt_mainOutReg;
    logic [SUS_LINES-1:0]  susDir_ff, susOutReg_ff, nxt_susDir, nxt_susOutReg;
    logic [CHIP_LINES-1:0] chipDir_ff, chipOutReg_ff, nxt_chipDir, nxt_chipOutReg;
    logic [`IRQ_WIDTH-1:0] irqStat_ff, irqEn_ff, nxt_irqStat, nxt_irqEn;
    logic [MAIN_LINES-1:0] mainPrev_ff;
    logic [CHIP_LINES-1:0] chipPrev_ff;
    logic                  usbPrev_ff;
    logic [31:0]           rdData, nxt_datO;
    logic [`IRQ_WIDTH-1:0] events;
    logic                  wrStrobe, rdStrobe, nxt_ack;
    gpio_assign_pkg::bus_state_t busState_ff, nxt_busState;


    // Event detectors compare the settled level with last cycle's settled level
    always_comb begin
        events = '0;
        events[`IRQ_WDOG_BIT]   = mainSync[`MAIN_WDOG_BIT] & ~mainPrev_ff[`MAIN_WDOG_BIT];
        events[`IRQ_USB_BIT]    = mainSync[`MAIN_USB_BIT] ^ usbPrev_ff;
        events[`IRQ_BATLOW_BIT] = ~chipSync[`CHIP_BATLOW_BIT] & chipPrev_ff[`CHIP_BATLOW_BIT];
        // Any connector line change raises one shared event
        events[`IRQ_CONN_BIT]   = |(chipSync[7:0] ^ chipPrev_ff[7:0]);
    end

    always_comb begin
        // Single-cycle ack; the idle state after each ack forces ack low for a cycle
        wrStrobe = 1'b0;
        rdStrobe = 1'b0;
        nxt_busState = gpio_assign_pkg::BUS_IDLE;
        if (busState_ff == gpio_assign_pkg::BUS_IDLE && wb_cyc_i && wb_stb_i) begin
            wrStrobe = wb_we_i;
            rdStrobe = ~wb_we_i;
            nxt_busState = gpio_assign_pkg::BUS_ACK;
        end
        nxt_ack = (nxt_busState == gpio_assign_pkg::BUS_ACK);
    end

    always_comb begin
        rdData = 32'h0;
        if (wb_adr_i == `MAIN_DIR_ADDR) begin
            rdData[MAIN_LINES-1:0] = mainDir_ff;
        end else if (wb_adr_i == `MAIN_OUT_ADDR) begin
            rdData[MAIN_LINES-1:0] = mainOutReg_ff;
        end else if (wb_adr_i == `MAIN_IN_ADDR) begin
            rdData[MAIN_LINES-1:0] = mainSync;
        end else if (wb_adr_i == `SUS_DIR_ADDR) begin
            rdData[SUS_LINES-1:0] = susDir_ff;
        end else if (wb_adr_i == `SUS_OUT_ADDR) begin
            rdData[SUS_LINES-1:0] = susOutReg_ff;
        end else if (wb_adr_i == `SUS_IN_ADDR) begin
            rdData[SUS_LINES-1:0] = susSync;
        end else if (wb_adr_i == `CHIP_DIR_ADDR) begin
            rdData[CHIP_LINES-1:0] = chipDir_ff;
        end else if (wb_adr_i == `CHIP_OUT_ADDR) begin
            rdData[CHIP_LINES-1:0] = chipOutReg_ff;
        end else if (wb_adr_i == `CHIP_IN_ADDR) begin
            rdData[CHIP_LINES-1:0] = chipSync;
        end else if (wb_adr_i == `STANDBY_ADDR) begin
            rdData[0] = s3Sync;
        end else if (wb_adr_i == `IRQ_STAT_ADDR) begin
            rdData[`IRQ_WIDTH-1:0] = irqStat_ff;
        end else if (wb_adr_i == `IRQ_EN_ADDR) begin
            rdData[`IRQ_WIDTH-1:0] = irqEn_ff;
        end else if (wb_adr_i == `IRQ_CLR_ADDR) begin
            // Write-only: reads return zero
            rdData = 32'h0;
        end else begin
            rdData = 32'h0;
        end
        nxt_datO = rdStrobe ? rdData : 32'h0;
    end

    // Byte-lane merge helper for registers of at most 16 bits
    function automatic logic [15:0] laneMerge(input logic [15:0] old, input logic [15:0] val,
                                             input logic [1:0] sel);
        logic [15:0] r;
        r = old;
        if (sel[0]) r[7:0] = val[7:0];
        if (sel[1]) r[15:8] = val[15:8];
        return r;
    endfunction

    always_comb begin
        logic [15:0] m;
        m = 16'h0;
        nxt_mainDir    = mainDir_ff;
        nxt_mainOutReg = mainOutReg_ff;
        nxt_susDir     = susDir_ff;
        nxt_susOutReg  = susOutReg_ff;
        nxt_chipDir    = chipDir_ff;
        nxt_chipOutReg = chipOutReg_ff;
        if (wrStrobe) begin
            if (wb_adr_i == `MAIN_DIR_ADDR) begin
                m = laneMerge(16'(mainDir_ff), wb_dat_i[15:0], wb_sel_i[1:0]);
                nxt_mainDir = m[MAIN_LINES-1:0] & `MAIN_DIR_MASK;
            end else if (wb_adr_i == `MAIN_OUT_ADDR) begin
                m = laneMerge(16'(mainOutReg_ff), wb_dat_i[15:0], wb_sel_i[1:0]);
                nxt_mainOutReg = m[MAIN_LINES-1:0];
            end else if (wb_adr_i == `SUS_DIR_ADDR) begin
                m = laneMerge(16'(susDir_ff), wb_dat_i[15:0], wb_sel_i[1:0]);
                nxt_susDir = m[SUS_LINES-1:0] & `SUS_DIR_MASK;
            end else if (wb_adr_i == `SUS_OUT_ADDR) begin
                m = laneMerge(16'(susOutReg_ff), wb_dat_i[15:0], wb_sel_i[1:0]);
                nxt_susOutReg = m[SUS_LINES-1:0];
            end else if (wb_adr_i == `CHIP_DIR_ADDR) begin
                m = laneMerge(16'(chipDir_ff), wb_dat_i[15:0], wb_sel_i[1:0]);
                nxt_chipDir = m[CHIP_LINES-1:0] & `CHIP_DIR_MASK;
            end else if (wb_adr_i == `CHIP_OUT_ADDR) begin
                m = laneMerge(16'(chipOutReg_ff), wb_dat_i[15:0], wb_sel_i[1:0]);
                nxt_chipOutReg = m[CHIP_LINES-1:0];
            end
        end
    end

    // Interrupt status and enable; both need byte lane 0
    always_comb begin
        nxt_irqEn   = irqEn_ff;
        nxt_irqStat = irqStat_ff;
        if (wrStrobe && wb_sel_i[0]) begin
            if (wb_adr_i == `IRQ_EN_ADDR) begin
                nxt_irqEn = wb_dat_i[`IRQ_WIDTH-1:0];
            end else if (wb_adr_i == `IRQ_CLR_ADDR) begin
                nxt_irqStat = irqStat_ff & ~wb_dat_i[`IRQ_WIDTH-1:0];
            end
        end
        // A new event wins over a clear in the same cycle
        nxt_irqStat = nxt_irqStat | events;
    end

    // Pin drive; main outputs float in S3, suspend outputs keep driving
    logic [MAIN_LINES-1:0] nxt_mainOe;
    logic [SUS_LINES-1:0]  nxt_susOe;
    logic [CHIP_LINES-1:0] nxt_chipOe;
    logic                  nxt_sdio;
    logic                  nxt_irq;

    always_comb begin
        // Masked again so a spare line can never drive, whatever the register holds
        nxt_mainOe = s3Sync ? '0 : (mainDir_ff & `MAIN_DIR_MASK);
        nxt_susOe  = susDir_ff & `SUS_DIR_MASK;
        nxt_chipOe = chipDir_ff & `CHIP_DIR_MASK;
        // Function select follows the line level, driven or pulled by the carrier
        nxt_sdio   = chipSync[`CHIP_SEL_BIT];
        nxt_irq    = |(nxt_irqStat & nxt_irqEn);
    end

    // Bus handshake
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            busState_ff <= gpio_assign_pkg::BUS_IDLE;
            wb_ack_o    <= 1'b0;
            wb_dat_o    <= 32'h0;
        end else begin
            busState_ff <= nxt_busState;
            wb_ack_o    <= nxt_ack;
            wb_dat_o    <= nxt_datO;
        end
    end

    // Software registers
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            mainDir_ff    <= `MAIN_DIR_RST;
            mainOutReg_ff <= '0;
            susDir_ff     <= `SUS_DIR_RST;
            susOutReg_ff  <= `SUS_OUT_RST;
            chipDir_ff    <= `CHIP_DIR_RST;
            chipOutReg_ff <= '0;
            irqStat_ff    <= `IRQ_RST;
            irqEn_ff      <= `IRQ_RST;
        end else begin
            mainDir_ff    <= nxt_mainDir;
            mainOutReg_ff <= nxt_mainOutReg;
            susDir_ff     <= nxt_susDir;
            susOutReg_ff  <= nxt_susOutReg;
            chipDir_ff    <= nxt_chipDir;
            chipOutReg_ff <= nxt_chipOutReg;
            irqStat_ff    <= nxt_irqStat;
            irqEn_ff      <= nxt_irqEn;
        end
    end

    // Edge history; cleared like the synchroniser, so a pin that is high at reset shows a false edge
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            mainPrev_ff <= '0;
            chipPrev_ff <= '0;
            usbPrev_ff  <= 1'b0;
        end else begin
            mainPrev_ff <= mainSync;
            chipPrev_ff <= chipSync;
            usbPrev_ff  <= mainSync[`MAIN_USB_BIT];
        end
    end

    // Registered pin drive, function select and interrupt
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            mainOut      <= '0;
            mainOe       <= '0;
            suspendOut   <= '0;
            suspendOe    <= '0;
            chipOut      <= '0;
            chipOe       <= '0;
            sdioSelected <= 1'b0;
            irq          <= 1'b0;
        end else begin
            mainOut      <= nxt_mainOutReg;
            mainOe       <= nxt_mainOe;
            suspendOut   <= nxt_susOutReg;
            suspendOe    <= nxt_susOe;
            chipOut      <= nxt_chipOutReg;
            chipOe       <= nxt_chipOe;
            sdioSelected <= nxt_sdio;
            irq          <= nxt_irq;
        end
    end
endmodule // module_gpio_line_assignment
`default_nettype wire

// *** module_gpio_line_assignment_tb.sv ***
// Self-checking bench for the GPIO line assignment block
`timescale 1ns/1ps
`default_nettype none
`include "gpio_assign_regs.svh"
module module_gpio_line_assignment_tb;
    logic        sys_clk, reset, cyc, stb, we, s3Standby, ack, sdioSelected, irq;
    logic [7:0]  adr;
    logic [31:0] datW, datR, rd;
    logic [4:0]  mainIn, mainOut, mainOe, extMain;
    logic [8:0]  suspendIn, suspendOut, suspendOe;
    logic [11:0] chipIn, chipOut, chipOe, extChip;
    int          badCount = 0;
    int          compares = 0;
    int          cycles = 0;
    module_gpio_line_assignment module_gpio_line_assignment_i (.sys_clk(sys_clk),
        .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'h3), .wb_dat_i(datW), .wb_dat_o(datR), .wb_ack_o(ack),
        .s3Standby(s3Standby), .mainIn(mainIn), .mainOut(mainOut), .mainOe(mainOe),
        .suspendIn(suspendIn), .suspendOut(suspendOut), .suspendOe(suspendOe),
        .chipIn(chipIn), .chipOut(chipOut), .chipOe(chipOe),
        .sdioSelected(sdioSelected), .irq(irq));
    // Pull-up kept on the panel I2C data line
    gpio_carrier_model gpio_carrier_model_i (.mainOut(mainOut), .mainOe(mainOe),
        .suspendOut(suspendOut), .suspendOe(suspendOe), .chipOut(chipOut), .chipOe(chipOe),
        .extMain(extMain), .extSus(9'h010), .extChip(extChip), .mainIn(mainIn),
        .suspendIn(suspendIn), .chipIn(chipIn));
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    task automatic giveVerdict;
        $display("compares %0d mismatches %0d", compares, badCount);
        if (badCount == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            badCount++;
            giveVerdict();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            badCount++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Holds the request until ack is sampled, then idles one cycle
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        datW <= d;
        do @(posedge sys_clk); while (ack !== 1'b1);
        rd = datR;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(rd, exp);
    endtask
    initial begin
        {reset, cyc, stb, we, s3Standby, adr, datW} = {5'h10, 8'h00, 32'h0};
        extMain = 5'h00;
        extChip = 12'h200;
        repeat (8) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        rdChk(`SUS_DIR_ADDR, 32'h0);
        rdChk(`MAIN_DIR_ADDR, 32'h0);
        bus(1'b1, 8'h3c, 32'hffff);
        rdChk(8'h3c, 32'h0);
        bus(1'b1, `IRQ_EN_ADDR, 32'hf);
        bus(1'b1, `IRQ_CLR_ADDR, 32'hf);
        extMain <= 5'h10;
        repeat (8) @(posedge sys_clk);
        rdChk(`IRQ_STAT_ADDR, 32'h1);
        check({31'h0, irq}, 32'h1);
        bus(1'b1, `IRQ_CLR_ADDR, 32'hf);
        extMain <= 5'h1a;
        repeat (8) @(posedge sys_clk);
        rdChk(`MAIN_IN_ADDR, 32'h1a);
        rdChk(`IRQ_STAT_ADDR, 32'h2);
        bus(1'b1, `IRQ_EN_ADDR, 32'hb);
        bus(1'b1, `IRQ_CLR_ADDR, 32'hf);
        extChip <= 12'h000;
        repeat (8) @(posedge sys_clk);
        rdChk(`IRQ_STAT_ADDR, 32'h4);
        check({31'h0, irq}, 32'h0);
        bus(1'b1, `MAIN_DIR_ADDR, 32'h1f);
        rdChk(`MAIN_DIR_ADDR, 32'h10);
        bus(1'b1, `MAIN_OUT_ADDR, 32'h10);
        check({27'h0, mainOe & mainOut}, 32'h10);
        bus(1'b1, `SUS_DIR_ADDR, 32'h1ff);
        rdChk(`SUS_DIR_ADDR, 32'h09f);
        bus(1'b1, `SUS_OUT_ADDR, 32'h09f);
        check({23'h0, suspendOe & suspendOut}, 32'h09f);
        s3Standby <= 1'b1;
        repeat (10) @(posedge sys_clk);
        check({27'h0, mainOe}, 32'h0);
        check({23'h0, suspendOe & suspendOut}, 32'h09f);
        s3Standby <= 1'b0;
        bus(1'b1, `CHIP_DIR_ADDR, 32'hfff);
        rdChk(`CHIP_DIR_ADDR, 32'h1ff);
        bus(1'b1, `CHIP_OUT_ADDR, 32'h100);
        repeat (8) @(posedge sys_clk);
        check({31'h0, sdioSelected}, 32'h1);
        bus(1'b1, `CHIP_OUT_ADDR, 32'h0);
        repeat (8) @(posedge sys_clk);
        check({31'h0, sdioSelected}, 32'h0);
        giveVerdict();
    end
endmodule // module_gpio_line_assignment_tb
`default_nettype wire
